//--- hdl/debug_port.sv
// What this block does
// (RULE_01) host clock plus one shared data line
// (RULE_02) registers reachable only over the link
// (RULE_03) 8-bit target select picks data register
// (RULE_04) select zero reads part identity
// (RULE_05) select one reads silicon revision
// (RULE_06) select two reaches programming control register
// (RULE_07) select b4 reaches programming data register
// (RULE_08) part identity fixed, read only
// (RULE_09) silicon revision read only, per silicon
// (RULE_10) programming enabled after 02 then 01
// (RULE_11) programming stays enabled until system reset
// (RULE_12) decode block read/write, page/device erase
// (RULE_13) host works while device halted
// (RULE_14) host loads select before data access
// (RULE_15) unmapped reads zero, bad writes ignored
`timescale 1ns/1ns
`default_nettype none
`include "dbg_defs.svh"

module debug_port #(
	parameter logic [7:0] PART_IDENTITY = 8'h5a, // arbitrary value
	parameter logic [7:0] SILICON_REVISION = 8'h3c // arbitrary value
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic debug_clock_pin,
	input wire logic debug_data_pin_in,
	output logic debug_data_pin_out,
	output logic debug_data_pin_oe,
	input wire logic flash_load,
	input wire logic [7:0] flash_load_data,
	output logic flash_prog_enabled,
	output dbg_pkg::flash_byte_t flash_byte
);

	typedef enum logic [1:0] {U_LOCKED, U_HALF, U_OPEN} unlock_t;

	dbg_pkg::link_req_t link_payload;
	logic link_req;
	logic req_s1_r, req_s2_r, req_s3_r;
	logic ack_r;
	logic [7:0] resp_r, resp_nxt;
	logic [7:0] target_r;
	logic [7:0] ctl_r;
	logic [7:0] data_r, data_nxt;
	unlock_t unlock_r, unlock_nxt;
	logic enabled_r;
	dbg_pkg::flash_byte_t byte_r, byte_nxt;

	// link side runs on the host's clock
	link_engine u_link (
		.link_clk(debug_clock_pin),
		.reset_n(reset_n),
		.data_in(debug_data_pin_in),
		.data_out(debug_data_pin_out),
		.data_oe(debug_data_pin_oe),
		.req_payload(link_payload),
		.req_toggle(link_req),
		.ack_toggle(ack_r),
		.resp_data(resp_r)
	); // RULE_01

	// request toggle crossing; first stage feeds only the second
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
			req_s3_r <= 1'b0;
		end else begin
			req_s1_r <= link_req;
			req_s2_r <= req_s1_r;
			req_s3_r <= req_s2_r;
		end
	end

	// payload is held by the link side until acked, so it is stable here
	wire req_edge = req_s2_r ^ req_s3_r;
	wire [7:0] wdata = link_payload.wdata;
	wire addr_wr = req_edge && link_payload.op == dbg_pkg::OP_ADDR_WRITE;
	wire addr_rd = req_edge && link_payload.op == dbg_pkg::OP_ADDR_READ;
	wire data_wr = req_edge && link_payload.op == dbg_pkg::OP_DATA_WRITE; // RULE_02
	wire data_rd = req_edge && link_payload.op == dbg_pkg::OP_DATA_READ; // RULE_02

	// target decode from the select register
	wire sel_ident = target_r == `SEL_IDENTITY; // RULE_04
	wire sel_rev = target_r == `SEL_REVISION; // RULE_05
	wire sel_ctl = target_r == `SEL_PROG_CTL; // RULE_06
	wire sel_data = target_r == `SEL_PROG_DATA; // RULE_07
	wire sel_mapped = sel_ident || sel_rev || sel_ctl || sel_data;

	// only the two read/write selections accept writes
	wire wr_ctl = data_wr && sel_ctl; // RULE_06 RULE_15
	wire wr_data = data_wr && sel_data; // RULE_07 RULE_15

	// read selection; identity codes are constants so writes cannot touch them
	wire [7:0] read_mux = sel_ident ? PART_IDENTITY : // RULE_04 RULE_08
		sel_rev ? SILICON_REVISION : // RULE_05 RULE_09
		sel_ctl ? ctl_r : // RULE_06
		sel_data ? data_r : // RULE_07
		`UNMAPPED_READ; // RULE_15

	// answer for the link, captured with the ack toggle
	always_comb begin
		resp_nxt = resp_r;
		if (data_rd) begin
			resp_nxt = read_mux; // RULE_03
		end else if (addr_rd) begin
			resp_nxt = target_r;
		end
	end

	// unlock sequence: 02 then 01; a repeated 02 keeps the first step, any other control register write starts over
	always_comb begin
		unlock_nxt = unlock_r;
		case (unlock_r)
			U_LOCKED: begin
				if (wr_ctl && wdata == `UNLOCK_FIRST) begin // RULE_10
					unlock_nxt = U_HALF;
				end
			end
			U_HALF: begin
				if (wr_ctl && wdata == `UNLOCK_SECOND) begin // RULE_10
					unlock_nxt = U_OPEN;
				end else if (wr_ctl && wdata != `UNLOCK_FIRST) begin
					unlock_nxt = U_LOCKED;
				end
			end
			U_OPEN: begin
				unlock_nxt = U_OPEN; // only reset leaves this state // RULE_11
			end
			default: begin
				unlock_nxt = U_LOCKED;
			end
		endcase
	end

	// host write beats an engine load landing in the same cycle
	always_comb begin
		data_nxt = data_r;
		if (wr_data) begin
			data_nxt = wdata; // RULE_07
		end else if (flash_load) begin
			data_nxt = flash_load_data;
		end
	end

	// bytes reach the engine only once programming is open
	always_comb begin
		byte_nxt = '{strobe: 1'b0, value: byte_r.value, kind: byte_r.kind};
		if (wr_data && enabled_r) begin
			byte_nxt.strobe = 1'b1;
			byte_nxt.value = wdata;
			case (wdata)
				`CMD_BLOCK_READ: byte_nxt.kind = dbg_pkg::K_BLOCK_READ; // RULE_12
				`CMD_BLOCK_WRITE: byte_nxt.kind = dbg_pkg::K_BLOCK_WRITE; // RULE_12
				`CMD_PAGE_ERASE: byte_nxt.kind = dbg_pkg::K_PAGE_ERASE; // RULE_12
				`CMD_DEVICE_ERASE: byte_nxt.kind = dbg_pkg::K_DEVICE_ERASE; // RULE_12
				default: byte_nxt.kind = dbg_pkg::K_NONE;
			endcase
		end
	end

	// select and control registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			target_r <= `TARGET_RESET;
			ctl_r <= `CTL_RESET;
		end else begin
			if (addr_wr) begin
				target_r <= wdata; // RULE_03
			end
			if (wr_ctl) begin
				ctl_r <= wdata; // RULE_06
			end
		end
	end

	// answer data and ack toggle move together
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_r <= 8'h00;
			ack_r <= 1'b0;
		end else begin
			resp_r <= resp_nxt;
			ack_r <= ack_r ^ req_edge;
		end
	end

	// unlock state, enable, data register and engine byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			unlock_r <= U_LOCKED;
			enabled_r <= 1'b0;
			data_r <= `DATA_RESET;
			byte_r <= '{strobe: 1'b0, value: 8'h00, kind: dbg_pkg::K_NONE};
		end else begin
			unlock_r <= unlock_nxt;
			enabled_r <= unlock_nxt == U_OPEN; // RULE_10 RULE_11
			data_r <= data_nxt;
			byte_r <= byte_nxt;
		end
	end

	assign flash_prog_enabled = enabled_r;
	assign flash_byte = byte_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_first_code;
		wr_ctl && wdata == `UNLOCK_FIRST && unlock_r == U_LOCKED;
	endsequence

	sequence s_second_code;
		wr_ctl && wdata == `UNLOCK_SECOND && unlock_r == U_HALF;
	endsequence

	// select register and the answers carried back over the link
	a_addr_load: assert property (addr_wr |=> target_r == $past(wdata)) // RULE_03
		else $error("target select did not take written address");

	a_addr_read: assert property (addr_rd |=> resp_r == $past(target_r)) // RULE_03
		else $error("select readback returned wrong value");

	// the link side copies the answer later, so it must not drift meanwhile
	a_resp_hold: assert property (!data_rd && !addr_rd |=> $stable(resp_r)) // RULE_03
		else $error("answer changed without a read request");

	// nothing but a taken link request may move select or control
	a_link_only: assert property (!req_edge |=> $stable(target_r) && $stable(ctl_r)) // RULE_02
		else $error("register changed without a link request");

	// fixed codes, read-only and unmapped selections
	a_ident_read: assert property (data_rd && sel_ident |=> resp_r == PART_IDENTITY) // RULE_04
		else $error("identity read returned wrong value");

	a_rev_read: assert property (data_rd && sel_rev |=> resp_r == SILICON_REVISION) // RULE_05
		else $error("revision read returned wrong value");

	a_ro_ignored: assert property (data_wr && (sel_ident || sel_rev) |=> // RULE_08
		$stable(ctl_r) && !byte_r.strobe && $stable(unlock_r))
		else $error("write to read-only selection had an effect");

	a_unmapped_zero: assert property (data_rd && !sel_mapped |=> resp_r == `UNMAPPED_READ) // RULE_15
		else $error("unmapped read not zero");

	a_bad_write: assert property (data_wr && !sel_ctl |=> $stable(ctl_r)) // RULE_15
		else $error("control register took a write aimed elsewhere");

	// programming control and data registers
	a_ctl_access: assert property (wr_ctl |=> ctl_r == $past(wdata)) // RULE_06
		else $error("control register did not take write");

	a_ctl_read: assert property (data_rd && sel_ctl |=> resp_r == $past(ctl_r)) // RULE_06
		else $error("control register did not read back");

	a_data_access: assert property (wr_data |=> data_r == $past(wdata)) // RULE_07
		else $error("data register did not take write");

	a_data_read: assert property (data_rd && sel_data |=> resp_r == $past(data_r)) // RULE_07
		else $error("data register did not read back");

	a_engine_load: assert property (flash_load && !wr_data |=> // RULE_07
		data_r == $past(flash_load_data))
		else $error("engine load did not reach data register");

	// unlock sequence and its stickiness
	a_unlock_half: assert property (s_first_code |=> unlock_r == U_HALF) // RULE_10
		else $error("first unlock code not taken");

	a_unlock_order: assert property (s_second_code |=> enabled_r) // RULE_10
		else $error("unlock codes in order did not enable");

	a_unlock_cause: assert property ($rose(enabled_r) |-> $past(wr_ctl && wdata == `UNLOCK_SECOND)) // RULE_10
		else $error("programming enabled without second code");

	a_unlock_quiet: assert property (!wr_ctl |=> $stable(unlock_r)) // RULE_10
		else $error("unlock state moved without a control write");

	a_enable_sticky: assert property (enabled_r |=> enabled_r [*8]) // RULE_11
		else $error("programming enable dropped before reset");

	// bytes towards the engine
	a_locked_quiet: assert property (!enabled_r |=> !byte_r.strobe) // RULE_12
		else $error("engine strobed while locked");

	a_strobe_pulse: assert property (byte_r.strobe |=> !byte_r.strobe) // RULE_12
		else $error("engine strobe longer than one cycle");

	a_cmd_value: assert property (wr_data && enabled_r |=> // RULE_12
		byte_r.strobe && byte_r.value == $past(wdata))
		else $error("engine byte not passed on");

	a_cmd_decode: assert property (wr_data && enabled_r && wdata == `CMD_PAGE_ERASE |=> // RULE_12
		byte_r.strobe && byte_r.kind == dbg_pkg::K_PAGE_ERASE ##1 !byte_r.strobe)
		else $error("page erase not decoded as one pulse");

	a_cmd_block_read: assert property (wr_data && enabled_r && wdata == `CMD_BLOCK_READ |=> // RULE_12
		byte_r.kind == dbg_pkg::K_BLOCK_READ)
		else $error("block read not decoded");

	a_cmd_block_write: assert property (wr_data && enabled_r && wdata == `CMD_BLOCK_WRITE |=> // RULE_12
		byte_r.kind == dbg_pkg::K_BLOCK_WRITE)
		else $error("block write not decoded");

	a_cmd_dev_erase: assert property (wr_data && enabled_r && wdata == `CMD_DEVICE_ERASE |=> // RULE_12
		byte_r.kind == dbg_pkg::K_DEVICE_ERASE)
		else $error("device erase not decoded");

	a_cmd_other: assert property (wr_data && enabled_r && wdata != `CMD_BLOCK_READ && // RULE_12
		wdata != `CMD_BLOCK_WRITE && wdata != `CMD_PAGE_ERASE && wdata != `CMD_DEVICE_ERASE |=>
		byte_r.kind == dbg_pkg::K_NONE)
		else $error("plain byte decoded as a command");

	// handshake back to the link side
	a_ack_follows: assert property (req_edge |=> ack_r != $past(ack_r) ##1 !req_edge) // RULE_01
		else $error("request not acknowledged next cycle");

endmodule : debug_port
`default_nettype wire

//--- hdl/link_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "dbg_defs.svh"

module link_engine (
	input wire logic link_clk,
	input wire logic reset_n,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe,
	output dbg_pkg::link_req_t req_payload,
	output logic req_toggle,
	input wire logic ack_toggle,
	input wire logic [7:0] resp_data
);

	typedef enum logic [2:0] {L_IDLE, L_INSTR, L_WDATA, L_WAIT, L_READY, L_RDATA} lstate_t;

	lstate_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [1:0] op_r, op_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic req_r, req_nxt;
	logic ack_s1_r, ack_s2_r;
	logic seen_r, seen_nxt;
	logic out_r, out_nxt;
	logic oe_r, oe_nxt;

	// decoded link conditions
	wire [1:0] op_shift = {data_in, op_r[1]};
	wire ack_edge = ack_s2_r ^ seen_r;
	wire [3:0] cnt_inc = cnt_r + `CNT_STEP;

	assign data_out = out_r;
	assign data_oe = oe_r;
	assign req_toggle = req_r;
	assign req_payload = '{op: dbg_pkg::op_t'(op_r), wdata: wdata_r};

	// frame sequencer; clock only runs while the host frames, so nothing waits outside one
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		op_nxt = op_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		req_nxt = req_r;
		seen_nxt = seen_r;
		out_nxt = out_r;
		oe_nxt = oe_r;
		case (state_r)
			L_IDLE: begin
				oe_nxt = 1'b0;
				if (!data_in) begin // start bit on the shared data line // RULE_01
					state_nxt = L_INSTR;
					cnt_nxt = `CNT_ZERO;
				end
			end
			L_INSTR: begin
				op_nxt = op_shift;
				cnt_nxt = cnt_inc;
				if (cnt_r == `INS_LAST) begin
					cnt_nxt = `CNT_ZERO;
					if (op_shift[0]) begin
						state_nxt = L_WDATA;
					end else begin
						req_nxt = ~req_r;
						state_nxt = L_WAIT;
						oe_nxt = 1'b1;
						out_nxt = 1'b0;
					end
				end
			end
			L_WDATA: begin
				wdata_nxt = {data_in, wdata_r[7:1]};
				cnt_nxt = cnt_inc;
				if (cnt_r == `DATA_LAST) begin
					req_nxt = ~req_r;
					state_nxt = L_WAIT;
					oe_nxt = 1'b1;
					out_nxt = 1'b0;
				end
			end
			L_WAIT: begin
				// hold wait low until the register side answers
				if (ack_edge) begin
					seen_nxt = ack_s2_r;
					rdata_nxt = resp_data;
					out_nxt = 1'b1;
					state_nxt = L_READY;
				end
			end
			L_READY: begin
				if (op_r[0]) begin
					oe_nxt = 1'b0;
					state_nxt = L_IDLE;
				end else begin
					out_nxt = rdata_r[0];
					cnt_nxt = `READ_FIRST;
					state_nxt = L_RDATA;
				end
			end
			L_RDATA: begin
				if (cnt_r == `READ_END) begin
					oe_nxt = 1'b0;
					state_nxt = L_IDLE;
				end else begin
					out_nxt = rdata_r[cnt_r[2:0]];
					cnt_nxt = cnt_inc;
				end
			end
			default: begin
				state_nxt = L_IDLE;
				oe_nxt = 1'b0;
			end
		endcase
	end

	// ack toggle crosses from the system clock through two flops
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end else begin
			ack_s1_r <= ack_toggle;
			ack_s2_r <= ack_s1_r;
		end
	end

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= L_IDLE;
			cnt_r <= `CNT_ZERO;
			op_r <= 2'h0;
			wdata_r <= 8'h00;
			rdata_r <= 8'h00;
			req_r <= 1'b0;
			seen_r <= 1'b0;
			out_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			op_r <= op_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			req_r <= req_nxt;
			seen_r <= seen_nxt;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
		end
	end

endmodule : link_engine
`default_nettype wire

//--- inc/dbg_defs.svh
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

// target selections held in the target select register
`define SEL_IDENTITY 8'h00
`define SEL_REVISION 8'h01
`define SEL_PROG_CTL 8'h02
`define SEL_PROG_DATA 8'hb4

// reset values and the unmapped read value
`define TARGET_RESET 8'h00
`define CTL_RESET 8'h00
`define DATA_RESET 8'h00
`define UNMAPPED_READ 8'h00

// unlock sequence written to the programming control register
`define UNLOCK_FIRST 8'h02
`define UNLOCK_SECOND 8'h01

// flash command codes carried by the programming data register
`define CMD_BLOCK_READ 8'h06
`define CMD_BLOCK_WRITE 8'h07
`define CMD_PAGE_ERASE 8'h08
`define CMD_DEVICE_ERASE 8'h03

// link frame bit counts
`define CNT_ZERO 4'h0
`define CNT_STEP 4'h1
`define INS_LAST 4'h1
`define DATA_LAST 4'h7
`define READ_FIRST 4'h1
`define READ_END 4'h8

`endif

//--- inc/dbg_pkg.sv
`default_nettype none

package dbg_pkg;

	// link operations, sent low bit first after the start bit
	typedef enum logic [1:0] {
		OP_DATA_READ,
		OP_DATA_WRITE,
		OP_ADDR_READ,
		OP_ADDR_WRITE
	} op_t;

	typedef enum logic [2:0] {
		K_NONE,
		K_BLOCK_READ,
		K_BLOCK_WRITE,
		K_PAGE_ERASE,
		K_DEVICE_ERASE
	} cmd_kind_t;

	// request held stable by the link side while its toggle is in flight
	typedef struct packed {
		op_t op;
		logic [7:0] wdata;
	} link_req_t;

	// byte handed to the flash engine
	typedef struct packed {
		logic strobe;
		logic [7:0] value;
		cmd_kind_t kind;
	} flash_byte_t;

endpackage : dbg_pkg

`default_nettype wire

//--- test/host_adapter.sv
`timescale 1ns/1ns
`default_nettype none

// host side of the link; its clock stands still between frames
module host_adapter (
	output logic link_clk,
	output logic drv_d,
	output logic drv_oe,
	input wire logic line
);
	initial begin
		link_clk = 1'b0;
		drv_d = 1'b1;
		drv_oe = 1'b0;
	end

	// drive just after the fall, sample at the rise before the device reacts
	task automatic cyc(input logic d, input logic oe, output logic s);
		drv_d = d;
		drv_oe = oe;
		#63;
		link_clk = 1'b1;
		s = line;
		#62;
		link_clk = 1'b0;
	endtask : cyc

	// one frame; ok stays low when ready never shows
	task automatic frame(input logic [1:0] op, input logic [7:0] wd,
		output logic [7:0] rd, output logic ok);
		logic s;
		int n;
		rd = 8'h00;
		cyc(1'b0, 1'b1, s);
		for (int i = 0; i < 2; i++) begin
			cyc(op[i], 1'b1, s);
		end
		for (int i = 0; i < 8 && op[0]; i++) begin
			cyc(wd[i], 1'b1, s);
		end
		// line released; the wait has no bound in link cycles, so cap it
		n = 0;
		do begin
			cyc(1'b1, 1'b0, s);
			n++;
		end while (s !== 1'b1 && n < 60);
		ok = (s === 1'b1);
		for (int i = 0; i < 8 && !op[0]; i++) begin
			cyc(1'b1, 1'b0, s);
			rd[i] = s;
		end
		cyc(1'b1, 1'b0, s);
	endtask : frame
endmodule : host_adapter

`default_nettype wire

//--- test/two_wire_debug_register_access_tb.sv
`timescale 1ns/1ns
`default_nettype none

module two_wire_debug_register_access_tb;
	localparam logic [7:0] ID_CODE = 8'h6e; // arbitrary value
	localparam logic [7:0] REV_CODE = 8'h29; // arbitrary value
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] wd;
		logic [7:0] exp;
	} row_t;
	typedef struct packed {
		logic [7:0] code;
		dbg_pkg::cmd_kind_t kind;
	} cmd_t;
	logic sys_clk;
	logic reset_n;
	logic flash_load;
	logic [7:0] flash_load_data;
	logic link_clk;
	logic drv_d;
	logic drv_oe;
	logic pin_out;
	logic pin_oe;
	logic prog_en;
	wire line;
	dbg_pkg::flash_byte_t fb;
	dbg_pkg::flash_byte_t last_fb;
	int n_mismatch;
	int n_tests;
	int n_strobe;
	logic [7:0] rd;
	int n;
	row_t rows [0:6] = '{
		'{8'h00, 8'h77, ID_CODE},
		'{8'h01, 8'h77, REV_CODE},
		'{8'h02, 8'h55, 8'h55},
		'{8'hb4, 8'ha5, 8'ha5},
		'{8'h03, 8'h11, 8'h00},
		'{8'hb3, 8'h11, 8'h00},
		'{8'hff, 8'h11, 8'h00}};
	cmd_t cmds [0:4] = '{
		'{8'h06, dbg_pkg::K_BLOCK_READ},
		'{8'h07, dbg_pkg::K_BLOCK_WRITE},
		'{8'h08, dbg_pkg::K_PAGE_ERASE},
		'{8'h03, dbg_pkg::K_DEVICE_ERASE},
		'{8'h5c, dbg_pkg::K_NONE}};

	// shared line: device, then host, else the pull-up
	assign line = pin_oe ? pin_out : (drv_oe ? drv_d : 1'b1);

	debug_port #(.PART_IDENTITY(ID_CODE), .SILICON_REVISION(REV_CODE)) DUT (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.debug_clock_pin(link_clk),
		.debug_data_pin_in(line),
		.debug_data_pin_out(pin_out),
		.debug_data_pin_oe(pin_oe),
		.flash_load(flash_load),
		.flash_load_data(flash_load_data),
		.flash_prog_enabled(prog_en),
		.flash_byte(fb)
	);

	host_adapter host (
		.link_clk(link_clk),
		.drv_d(drv_d),
		.drv_oe(drv_oe),
		.line(line)
	);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// strobes stand one cycle; look mid-cycle, away from the edge that moves them
	always @(negedge sys_clk) begin
		if (fb.strobe === 1'b1) begin
			n_strobe++;
			last_fb = fb;
		end
	end

	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// a stalled frame ends the run at once
	task automatic xfer(input logic [1:0] op, input logic [7:0] wd, output logic [7:0] r);
		logic ok;
		host.frame(op, wd, r, ok);
		n_tests++;
		if (ok !== 1'b1 || pin_oe !== 1'b0) begin
			n_mismatch++;
			$display("Error %0t: frame did not complete", $time);
			conclude();
		end
	endtask : xfer

	task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] wd,
		output logic [7:0] r);
		logic [7:0] t;
		xfer(dbg_pkg::OP_ADDR_WRITE, a, t);
		xfer(dbg_pkg::OP_ADDR_READ, 8'h00, t);
		check(t, a, "select readback");
		if (wr)
			xfer(dbg_pkg::OP_DATA_WRITE, wd, t);
		xfer(dbg_pkg::OP_DATA_READ, 8'h00, r);
	endtask : access

	task automatic do_reset();
		@(negedge sys_clk);
		reset_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		@(negedge sys_clk);
	endtask : do_reset

	initial begin
		reset_n = 1'b0;
		flash_load = 1'b0;
		flash_load_data = 8'h00;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		@(negedge sys_clk);
		#17;
		check({7'h00, prog_en}, 8'h00, "enable after reset");
		xfer(dbg_pkg::OP_ADDR_READ, 8'h00, rd);
		check(rd, 8'h00, "select reset");
		// writes go in before unlock, so none may strobe the engine
		for (int i = 0; i < 7; i++) begin
			access(rows[i].sel, 1'b1, rows[i].wd, rd);
			check(rd, rows[i].exp, "row data");
		end
		check(8'(n_strobe), 8'h00, "strobe while locked");
		// 02 broken by 05, then 01, stays locked
		access(8'h02, 1'b1, 8'h02, rd);
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h05, rd);
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h01, rd);
		check({7'h00, prog_en}, 8'h00, "bad unlock");
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h02, rd);
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h02, rd);
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h01, rd);
		check({7'h00, prog_en}, 8'h01, "unlock");
		xfer(dbg_pkg::OP_DATA_WRITE, 8'h00, rd);
		check({7'h00, prog_en}, 8'h01, "enable sticky");
		xfer(dbg_pkg::OP_ADDR_WRITE, 8'hb4, rd);
		for (int i = 0; i < 5; i++) begin
			n = n_strobe;
			xfer(dbg_pkg::OP_DATA_WRITE, cmds[i].code, rd);
			check(8'(n_strobe - n), 8'h01, "strobe count");
			check(last_fb.value, cmds[i].code, "command byte");
			check({5'h00, last_fb.kind}, {5'h00, cmds[i].kind}, "command kind");
		end
		// engine loads a byte between frames only, as if the device were halted
		@(negedge sys_clk);
		flash_load_data = 8'hc3;
		flash_load = 1'b1;
		@(negedge sys_clk);
		flash_load = 1'b0;
		xfer(dbg_pkg::OP_DATA_READ, 8'h00, rd);
		check(rd, 8'hc3, "engine load");
		do_reset();
		check({7'h00, prog_en}, 8'h00, "enable cleared");
		access(8'hb4, 1'b0, 8'h00, rd);
		check(rd, 8'h00, "data reset");
		access(8'h02, 1'b0, 8'h00, rd);
		check(rd, 8'h00, "control reset");
		conclude();
	end
endmodule : two_wire_debug_register_access_tb

`default_nettype wire
